/* rtl/fbspc_pin_ctrl.sv */
/*
  Pin-control block of a fieldbus I/O slave: strap capture, indicators,
  consistency pre-announce and the four-wire EEPROM / shift-register engine.
  Assumes straps and pins are asynchronous; request pulses come from logic on clk.
*/
`timescale 1ns/10ps
module fbspc_pin_ctrl (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       clock_freq_select,
  input  wire logic                       memory_or_shiftreg_select,
  input  wire logic [4:0]                 port_type_strap,
  input  wire logic                       addr_change_allowed,
  input  wire logic                       test_mode_in_a,
  input  wire logic                       test_mode_in_b,
  input  wire logic [7:0]                 diag_port_in,
  input  wire logic                       periph_data_in,
  input  wire logic                       wd_timeout,
  input  wire logic                       prm_valid,
  input  wire logic                       prm_broadcast,
  input  wire logic [6:0]                 destination_address,
  input  wire logic [6:0]                 station_address,
  input  wire logic [3:0]                 baud_code,
  input  wire logic                       rd_req,
  input  wire logic                       wr_req,
  input  wire logic                       addr_lock,
  input  wire logic [15:0]                wr_word,
  input  wire logic                       cons_req,
  output logic                            straps_valid,
  output logic                            freq_is_48,
  output logic                            eeprom_mode,
  output fbspc_pkg::fbspc_port_cfg_t      port_cfg,
  output logic                            baud_ok,
  output logic                            test_mode_fault,
  output logic                            diag_error_out,
  output logic                            normal_operation_out,
  output logic                            periph_clock_out,
  output logic                            periph_select_out,
  output logic                            periph_data_or_load_out,
  output logic                            busy,
  output logic                            wr_refused,
  output logic [15:0]                     rd_word,
  output logic                            rd_done,
  output logic                            consistency_preannounce,
  output logic                            cons_go
);

  typedef struct packed {
    logic [fbspc_pkg::SY_W-1:0] sy1;
    logic [fbspc_pkg::SY_W-1:0] sy2;
    logic [fbspc_pkg::SY_W-1:0] sy3;
    logic [fbspc_pkg::SY_W-1:0] filt;
    logic [1:0]                 init_cnt;
    logic                       cap_done;
    logic                       f48;
    logic                       eep;
    logic [4:0]                 typ;
    logic                       diag_err;
    logic                       normal;
    logic                       unlock;
    fbspc_pkg::fbspc_fsm_t      fsm;
    logic [7:0]                 tick_cnt;
    fbspc_pkg::fbspc_periph_t   pin;
    logic                       wr_op;
    logic [4:0]                 bit_cnt;
    logic [15:0]                sh;
    logic [15:0]                rd_data;
    logic                       rd_done;
    logic                       refused;
    logic [7:0]                 cons_cnt;
    logic                       cons_o;
    logic                       cons_go;
  } fbspc_state_t;

  fbspc_state_t st_r;
  fbspc_state_t st_nxt;
  logic         tick;
  logic [7:0]   half_cnt;
  logic [fbspc_pkg::SY_W-1:0] raw;

  // Port layout decode, drives the port_cfg output
  function automatic fbspc_pkg::fbspc_port_cfg_t fbspc_decode(input logic [4:0] t);
    fbspc_pkg::fbspc_port_cfg_t c;
    c.num_ports  = 3'({1'b0, t[1:0]}) + 3'h1;
    c.dir_out    = t[2];
    c.consistent = t[3];
    c.ext_diag   = t[4];
    return c;
  endfunction : fbspc_decode

  // Highest rate needs the 48 MHz clock
  function automatic logic fbspc_baud_ok(input logic [3:0] code, input logic f48);
    return (code <= fbspc_pkg::BAUD_6M) || (code == fbspc_pkg::BAUD_12M && f48);
  endfunction : fbspc_baud_ok

  assign raw = {diag_port_in, periph_data_in, test_mode_in_b, test_mode_in_a, addr_change_allowed,
                port_type_strap, memory_or_shiftreg_select, clock_freq_select};

  // Divider reload follows the captured frequency strap
  assign half_cnt = st_r.f48 ? 8'(fbspc_pkg::HALF_48) : 8'(fbspc_pkg::HALF_24);
  assign tick     = (st_r.tick_cnt == 8'h00);

  // Next-state logic
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.rd_done = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.cons_go = 1'b0;
    // Three-stage sync; filtered value moves only when stages two and three agree
    st_nxt.sy1 = raw;
    st_nxt.sy2 = st_r.sy1;
    st_nxt.sy3 = st_r.sy2;
    for (int i = 0; i < fbspc_pkg::SY_W; i++)
    begin
      if (st_r.sy2[i] == st_r.sy3[i])
        st_nxt.filt[i] = st_r.sy2[i];
    end
    // Straps latched once from this edge's filter value; the registered copy still holds reset
    if (!st_r.cap_done)
    begin
      if (st_r.init_cnt == 2'h3)
      begin
        st_nxt.cap_done = 1'b1;
        st_nxt.f48      = st_nxt.filt[fbspc_pkg::SY_F48];
        st_nxt.eep      = st_nxt.filt[fbspc_pkg::SY_EEP];
        st_nxt.typ      = st_nxt.filt[fbspc_pkg::SY_TYP +: 5];
      end
      else
        st_nxt.init_cnt = st_r.init_cnt + 2'h1;
    end
    st_nxt.diag_err = ~&st_r.filt[fbspc_pkg::SY_DIAG +: 8];
    // Set wins over a same-cycle watchdog clear
    if (prm_valid && !prm_broadcast && destination_address == station_address)
      st_nxt.normal = 1'b1;
    else if (wd_timeout)
      st_nxt.normal = 1'b0;
    // Consistency lead: output stands for a fixed lead, then the access strobe
    if (st_r.cons_o)
    begin
      if (st_r.cons_cnt == 8'h01)
      begin
        st_nxt.cons_o  = 1'b0;
        st_nxt.cons_go = 1'b1;
      end
      st_nxt.cons_cnt = st_r.cons_cnt - 8'h01;
    end
    else if (cons_req && st_r.cap_done)
    begin
      st_nxt.cons_o   = 1'b1;
      st_nxt.cons_cnt = 8'(fbspc_pkg::CONS_LEAD_CYC);
    end
    // Bit-rate divider, free running while an operation is in progress
    if (st_r.fsm == fbspc_pkg::FBSPC_IDLE || tick)
      st_nxt.tick_cnt = half_cnt - 8'h01;
    else
      st_nxt.tick_cnt = st_r.tick_cnt - 8'h01;
    // Peripheral engine
    unique case (st_r.fsm)
      fbspc_pkg::FBSPC_IDLE:
      begin
        if (st_r.cap_done && rd_req)
        begin
          st_nxt.fsm   = fbspc_pkg::FBSPC_SELECT;
          st_nxt.wr_op = 1'b0;
          st_nxt.pin.sel       = 1'b1;
          st_nxt.pin.data_load = !st_r.eep;
        end
        else if (st_r.cap_done && wr_req)
        begin
          // Lock bypass only with a memory fitted; strap pin is dead otherwise
          if (st_r.eep && (!addr_lock || st_r.unlock || st_r.filt[fbspc_pkg::SY_ACA]))
          begin
            st_nxt.fsm     = fbspc_pkg::FBSPC_SELECT;
            st_nxt.wr_op   = 1'b1;
            st_nxt.sh      = wr_word;
            st_nxt.unlock  = 1'b0;
            st_nxt.pin.sel = 1'b1;
          end
          else
            st_nxt.refused = 1'b1;
        end
      end
      fbspc_pkg::FBSPC_SELECT:
      begin
        if (tick)
        begin
          st_nxt.fsm           = fbspc_pkg::FBSPC_SHIFT;
          st_nxt.bit_cnt       = 5'h00;
          st_nxt.pin.data_load = st_r.eep && st_r.wr_op && st_r.sh[15];
        end
      end
      fbspc_pkg::FBSPC_SHIFT:
      begin
        if (tick && !st_r.pin.clk)
        begin
          st_nxt.pin.clk = 1'b1;
          if (!st_r.wr_op)
            st_nxt.sh = {st_r.sh[14:0], st_r.filt[fbspc_pkg::SY_DI]};
        end
        else if (tick)
        begin
          st_nxt.pin.clk = 1'b0;
          st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
          if (st_r.wr_op)
          begin
            st_nxt.sh            = {st_r.sh[14:0], 1'b0};
            st_nxt.pin.data_load = st_r.sh[14];
          end
          if (st_r.bit_cnt == 5'(fbspc_pkg::WORD_BITS - 1))
          begin
            st_nxt.fsm           = fbspc_pkg::FBSPC_DONE;
            st_nxt.pin.data_load = 1'b0;
          end
        end
      end
      fbspc_pkg::FBSPC_DONE:
      begin
        st_nxt.fsm     = fbspc_pkg::FBSPC_IDLE;
        st_nxt.pin.sel = 1'b0;
        if (!st_r.wr_op)
        begin
          st_nxt.rd_data = st_r.sh;
          st_nxt.rd_done = 1'b1;
        end
      end
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r        <= '0;
      st_r.normal <= fbspc_pkg::RST_NORMAL;
      st_r.unlock <= fbspc_pkg::RST_UNLOCK;
      st_r.fsm    <= fbspc_pkg::FBSPC_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign straps_valid            = st_r.cap_done;
  assign freq_is_48              = st_r.f48;
  assign eeprom_mode             = st_r.eep;
  assign port_cfg                = fbspc_decode(st_r.typ);
  assign baud_ok                 = fbspc_baud_ok(baud_code, st_r.f48);
  assign test_mode_fault         = !(st_r.filt[fbspc_pkg::SY_TMA] && st_r.filt[fbspc_pkg::SY_TMB]);
  assign diag_error_out          = st_r.diag_err;
  assign normal_operation_out    = st_r.normal;
  assign periph_clock_out        = st_r.pin.clk;
  assign periph_select_out       = st_r.pin.sel;
  assign periph_data_or_load_out = st_r.pin.data_load;
  assign busy                    = (st_r.fsm != fbspc_pkg::FBSPC_IDLE);
  assign wr_refused              = st_r.refused;
  assign rd_word                 = st_r.rd_data;
  assign rd_done                 = st_r.rd_done;
  assign consistency_preannounce = st_r.cons_o;
  assign cons_go                 = st_r.cons_go;

  // Helper counts; long spans are counted since deep repetitions get unrolled
  logic [7:0]  lead_cnt_r;
  logic [10:0] busy_cnt_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      {lead_cnt_r, busy_cnt_r} <= 19'h00000;
    else
    begin
      lead_cnt_r <= consistency_preannounce ? lead_cnt_r + 8'h01 : 8'h00;
      busy_cnt_r <= busy ? busy_cnt_r + 11'h001 : 11'h000;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_diag_error_level: assert property ((&st_r.filt[fbspc_pkg::SY_DIAG +: 8]) |=> !diag_error_out)
    else $error("diag error high with all diag inputs high");
  chk_diag_error_set: assert property ((!(&st_r.filt[fbspc_pkg::SY_DIAG +: 8])) |=> diag_error_out)
    else $error("diag error not raised");
  chk_normal_wd_clear: assert property (wd_timeout && !prm_valid |=> !normal_operation_out)
    else $error("normal indicator survived watchdog expiry");
  chk_normal_no_bcast: assert property (!normal_operation_out && prm_valid && prm_broadcast |=> !normal_operation_out)
    else $error("broadcast set normal indicator");
  chk_normal_match_set: assert property (prm_valid && !prm_broadcast && destination_address == station_address
                                         |=> normal_operation_out)
    else $error("matching telegram did not set normal indicator");
  chk_shiftreg_refuse: assert property (!busy && st_r.cap_done && !eeprom_mode && wr_req && !rd_req
                                        |=> wr_refused && !busy)
    else $error("write accepted in shift-register mode");
  chk_aca_bypass: assert property (!busy && st_r.cap_done && eeprom_mode && wr_req && !rd_req && addr_lock
                                   && st_r.filt[fbspc_pkg::SY_ACA] |=> busy && periph_select_out)
    else $error("address change refused despite permission");
  chk_cons_lead: assert property ($fell(consistency_preannounce) |-> cons_go
                                  && lead_cnt_r == 8'(fbspc_pkg::CONS_LEAD_CYC))
    else $error("consistency lead wrong length");
  chk_select_frames: assert property (periph_clock_out |-> periph_select_out)
    else $error("peripheral clock outside select");
  chk_sr_load_first: assert property ($rose(periph_select_out) && !eeprom_mode |-> periph_data_or_load_out)
    else $error("no load strobe in shift-register mode");
  chk_read_done: assert property ($fell(busy) && !st_r.wr_op |-> rd_done)
    else $error("read ended without done pulse");
  chk_read_bounded: assert property (busy_cnt_r <= 11'(2 * fbspc_pkg::HALF_48 * (fbspc_pkg::WORD_BITS + 1)))
    else $error("peripheral operation did not finish");
  chk_baud_12m: assert property (baud_code == fbspc_pkg::BAUD_12M |-> baud_ok == freq_is_48)
    else $error("12 MBd support does not follow frequency strap");
  chk_strap_hold: assert property (straps_valid |=> $stable(freq_is_48) && $stable(eeprom_mode))
    else $error("strap capture changed");

  cov_eep_write: cover property ($rose(busy) && eeprom_mode && st_r.wr_op);
  cov_sr_read: cover property (rd_done && !eeprom_mode);
  cov_normal_up: cover property ($rose(normal_operation_out));
  cov_cons: cover property (cons_go);

endmodule : fbspc_pin_ctrl

/* rtl/fbspc_pkg.sv */
/*
  Shared constants and carrier types for the fieldbus slave pin-control block.
  Assumes a single 100 MHz core clock; strap nominal rates are 24 or 48 MHz.
*/
package fbspc_pkg;
  // Sync vector bit positions
  localparam int SY_F48  = 0;
  localparam int SY_EEP  = 1;
  localparam int SY_TYP  = 2;
  localparam int SY_ACA  = 7;
  localparam int SY_TMA  = 8;
  localparam int SY_TMB  = 9;
  localparam int SY_DI   = 10;
  localparam int SY_DIAG = 11;
  localparam int SY_W    = 19;

  // Timing
  localparam int CLK_PERIOD_NS   = 10;
  localparam int NOM_24_KHZ      = 24000;
  localparam int NOM_48_KHZ      = 48000;
  localparam int PERIPH_CLK_KHZ  = 500;
  localparam int HALF_24         = NOM_24_KHZ / (2 * PERIPH_CLK_KHZ);
  localparam int HALF_48         = NOM_48_KHZ / (2 * PERIPH_CLK_KHZ);
  localparam int CONS_LEAD_NS    = 100;
  localparam int CONS_LEAD_CYC   = (CONS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WORD_BITS       = 16;

  // Baud codes: 0 is 9.6 kBd ... 8 is 6 MBd, 9 is 12 MBd
  localparam logic [3:0] BAUD_6M  = 4'h8;
  localparam logic [3:0] BAUD_12M = 4'h9;

  // Reset values
  localparam logic       RST_NORMAL = 1'b0;
  localparam logic       RST_UNLOCK = 1'b1;

  typedef enum logic [1:0] {
    FBSPC_IDLE   = 2'b00,
    FBSPC_SELECT = 2'b01,
    FBSPC_SHIFT  = 2'b11,
    FBSPC_DONE   = 2'b10
  } fbspc_fsm_t;

  typedef struct packed {
    logic [2:0] num_ports;
    logic       dir_out;
    logic       consistent;
    logic       ext_diag;
  } fbspc_port_cfg_t;

  typedef struct packed {
    logic       clk;
    logic       sel;
    logic       data_load;
  } fbspc_periph_t;
endpackage : fbspc_pkg

/* dv/fbspc_periph_model.sv */
/*
  Far-side model of the four-wire port: parallel-load shift register or serial memory.
  Assumes the block frames each transfer with select and shifts 16 bits MSB first.
*/
`timescale 1ns/10ps
module fbspc_periph_model (
  input  wire logic        clk,
  input  wire logic        eeprom_mode,
  input  wire logic        periph_clock_out,
  input  wire logic        periph_select_out,
  input  wire logic        periph_data_or_load_out,
  input  wire logic [15:0] src_word,
  output logic             periph_data_in,
  output logic [15:0]      last_shifted
);
  logic [15:0] shadow_r;
  logic [3:0]  idx_r;
  logic        idle_r = 1'b0;

  // Parallel capture on the load strobe in register mode
  always @(posedge periph_data_or_load_out)
    if (!eeprom_mode)
      shadow_r <= src_word;

  // Bit pointer restarts with each frame and steps on falling clock
  always @(posedge periph_select_out)
    idx_r <= 4'hF;
  always @(negedge periph_clock_out)
    if (periph_select_out)
      idx_r <= idx_r - 4'h1;

  // Write bits taken on rising clock, as a memory would
  always @(posedge periph_clock_out)
    if (periph_select_out)
      last_shifted <= {last_shifted[14:0], periph_data_or_load_out};

  // Released line toggles so a stale bit never passes as data
  always @(posedge clk)
    idle_r <= ~idle_r;

  // Serial data, MSB first, only while selected
  assign periph_data_in = periph_select_out ? (eeprom_mode ? src_word[idx_r] : shadow_r[idx_r]) : idle_r;
endmodule : fbspc_periph_model

/* dv/tb_fbspc_pin_ctrl.sv */
/*
  Self-checking bench for the pin-control block with a far-side peripheral model.
  Assumes the package constants and the hand-over timing of the block.
*/
`timescale 1ns/10ps
module tb_fbspc_pin_ctrl;
  logic        clk, rst_b, clock_freq_select, memory_or_shiftreg_select, addr_change_allowed;
  logic        test_mode_in_a, test_mode_in_b, periph_data_in, wd_timeout, prm_valid, prm_broadcast;
  logic        rd_req, wr_req, addr_lock, cons_req, straps_valid, freq_is_48, eeprom_mode, baud_ok;
  logic        test_mode_fault, diag_error_out, normal_operation_out, periph_clock_out, periph_select_out;
  logic        periph_data_or_load_out, busy, wr_refused, rd_done, consistency_preannounce, cons_go;
  logic [4:0]  port_type_strap;
  logic [7:0]  diag_port_in;
  logic [6:0]  destination_address, station_address;
  logic [3:0]  baud_code;
  logic [15:0] wr_word, rd_word, src_word, last_shifted;
  logic [15:0] rd_q[$];
  logic        ref_q[$];
  int          cons_q[$];
  int          failures, checks_done, seed, lead, rises, n, i;
  fbspc_pkg::fbspc_port_cfg_t port_cfg;

  fbspc_pin_ctrl u_fbspc_pin_ctrl (.clk, .rst_b, .clock_freq_select, .memory_or_shiftreg_select,
    .port_type_strap, .addr_change_allowed, .test_mode_in_a, .test_mode_in_b, .diag_port_in,
    .periph_data_in, .wd_timeout, .prm_valid, .prm_broadcast, .destination_address, .station_address,
    .baud_code, .rd_req, .wr_req, .addr_lock, .wr_word, .cons_req, .straps_valid, .freq_is_48,
    .eeprom_mode, .port_cfg, .baud_ok, .test_mode_fault, .diag_error_out, .normal_operation_out,
    .periph_clock_out, .periph_select_out, .periph_data_or_load_out, .busy, .wr_refused, .rd_word,
    .rd_done, .consistency_preannounce, .cons_go);

  fbspc_periph_model u_fbspc_periph_model (.clk, .eeprom_mode, .periph_clock_out, .periph_select_out,
    .periph_data_or_load_out, .src_word, .periph_data_in, .last_shifted);

  // Free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    chk("pending", 16'h0, 16'(rd_q.size() + ref_q.size() + cons_q.size()));
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // Bounded wait for the engine; reads at 48 MHz take about 1600 cycles
  task automatic wait_idle;
    for (n = 0; n < 3000 && busy !== 1'b0; n++)
      #10;
    if (busy !== 1'b0)
    begin
      chk("busy_timeout", 16'h0, 16'h1);
      complete_run();
    end
  endtask : wait_idle

  // Straps only move while reset holds the part
  task automatic do_reset(input logic f48, input logic eep, input logic [4:0] typ);
    @(posedge clk);
    rst_b <= 1'b0;
    clock_freq_select <= f48;
    memory_or_shiftreg_select <= eep;
    port_type_strap <= typ;
    station_address <= 7'($random(seed));
    repeat (2) @(posedge clk);
    #1;
    chk("normal_rst", 16'h0, 16'(normal_operation_out));
    chk("select_rst", 16'h0, 16'(periph_select_out));
    @(posedge clk);
    rst_b <= 1'b1;
    for (n = 0; n < 20 && straps_valid !== 1'b1; n++)
      @(posedge clk);
    #1;
    chk("straps_valid", 16'h1, 16'(straps_valid));
    if (straps_valid !== 1'b1)
      complete_run();
    chk("test_mode", 16'h0, 16'(test_mode_fault));
    chk("freq", 16'(f48), 16'(freq_is_48));
    chk("mode", 16'(eep), 16'(eeprom_mode));
    chk("port_cfg", 16'({3'(typ[1:0]) + 3'h1, typ[2], typ[3], typ[4]}), 16'(port_cfg));
  endtask : do_reset

  task automatic do_prm(input logic v, input logic wd, input logic bc, input logic match, input logic exp);
    @(posedge clk);
    prm_valid <= v;
    wd_timeout <= wd;
    prm_broadcast <= bc;
    destination_address <= match ? station_address : ~station_address;
    @(posedge clk);
    prm_valid <= 1'b0;
    wd_timeout <= 1'b0;
    #1;
    chk("normal", 16'(exp), 16'(normal_operation_out));
  endtask : do_prm

  task automatic do_read(input logic eep);
    @(posedge clk);
    src_word <= 16'($random(seed));
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
    rd_q.push_back(src_word);
    rises = 0;
    #1;
    chk("select", 16'h1, 16'(periph_select_out));
    chk("load", 16'(!eep), 16'(periph_data_or_load_out));
    wait_idle();
    chk("clk_rises", 16'h10, 16'(rises));
  endtask : do_read

  task automatic do_write(input logic lock, input logic aca, input logic refuse);
    logic [15:0] w;
    w = 16'($random(seed));
    @(posedge clk);
    addr_change_allowed <= aca;
    repeat (6) @(posedge clk);
    wr_req <= 1'b1;
    addr_lock <= lock;
    wr_word <= w;
    if (refuse)
      ref_q.push_back(1'b1);
    @(posedge clk);
    wr_req <= 1'b0;
    #1;
    wait_idle();
    repeat (3) @(posedge clk);
    if (!refuse)
      chk("written", w, last_shifted);
  endtask : do_write

  // Second request inside the lead must be ignored
  task automatic do_cons;
    @(posedge clk);
    cons_req <= 1'b1;
    cons_q.push_back(fbspc_pkg::CONS_LEAD_CYC);
    @(posedge clk);
    cons_req <= 1'b0;
    repeat (3) @(posedge clk);
    cons_req <= 1'b1;
    @(posedge clk);
    cons_req <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : do_cons

  always @(posedge periph_clock_out)
    rises++;

  // Result watcher: pops the oldest note whenever a result appears
  always @(posedge clk)
  begin
    if (consistency_preannounce === 1'b1)
      lead++;
    if (rd_done === 1'b1)
      chk("rd_word", (rd_q.size() > 0) ? rd_q.pop_front() : 16'hXXXX, rd_word);
    if (wr_refused === 1'b1)
      chk("refused", (ref_q.size() > 0) ? 16'(ref_q.pop_front()) : 16'h0, 16'h1);
    if (cons_go === 1'b1)
    begin
      chk("lead", (cons_q.size() > 0) ? 16'(cons_q.pop_front()) : 16'hXXXX, 16'(lead));
      chk("ann_off", 16'h0, 16'(consistency_preannounce));
    end
    if (cons_go === 1'b1 || rst_b === 1'b0)
      lead = 0;
  end

  // Main sequence; test inputs stay high throughout
  initial
  begin
    seed = 61627;
    {failures, checks_done, lead, rises} = '0;
    {rst_b, clock_freq_select, memory_or_shiftreg_select, addr_change_allowed} = 4'h0;
    {wd_timeout, prm_valid, prm_broadcast, rd_req, wr_req, addr_lock, cons_req} = 7'h00;
    test_mode_in_a = 1'b1;
    test_mode_in_b = 1'b1;
    {port_type_strap, destination_address, station_address, baud_code} = 23'h000000;
    diag_port_in = 8'hFF;
    wr_word = 16'h0000;
    src_word = 16'h0000;
    for (i = 0; i < 4; i++)
    begin
      do_reset(i[0], i[1], 5'($random(seed)));
      for (n = 0; n < 16; n++)
      begin
        @(posedge clk);
        baud_code <= 4'(n);
        #1;
        chk("baud_ok", 16'((n <= 8) || (n == 9 && i[0])), 16'(baud_ok));
      end
    end
    $display("test straps done");
    do_reset(1'b0, 1'b0, 5'($random(seed)));
    do_prm(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    do_prm(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    do_prm(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    do_prm(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    do_prm(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    do_prm(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    $display("test indicator done");
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk);
      diag_port_in <= (i == 0) ? 8'hFF : 8'($random(seed));
      repeat (8) @(posedge clk);
      #1;
      chk("diag", 16'(diag_port_in != 8'hFF), 16'(diag_error_out));
    end
    $display("test diag done");
    do_read(1'b0);
    do_read(1'b0);
    do_write(1'b0, 1'b1, 1'b1);
    do_cons();
    $display("test shift register done");
    do_reset(1'b1, 1'b1, 5'($random(seed)));
    do_read(1'b1);
    do_write(1'b1, 1'b0, 1'b0);
    do_write(1'b1, 1'b0, 1'b1);
    do_write(1'b1, 1'b1, 1'b0);
    do_write(1'b0, 1'b0, 1'b0);
    $display("test memory done");
    complete_run();
  end
endmodule : tb_fbspc_pin_ctrl
